/* ddr_fifo.sv */
// Transmit pair FIFO with valid and ready on both sides
`timescale 1ns/10ps
module ddr_fifo
  import ddr_pkg::*;
#(
  parameter int unsigned WIDTH = DDR_PAIR_W,
  parameter int unsigned DEPTH = DDR_FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("ddr_fifo needs a power-of-two depth of at least two");
    end
  endgenerate
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wptr_reg;
  logic [AW:0] rptr_reg;
  wire empty = (wptr_reg == rptr_reg);
  wire full = (wptr_reg[AW-1:0] == rptr_reg[AW-1:0]) && (wptr_reg[AW] != rptr_reg[AW]);
  wire do_wr = ce_in && wr_valid_in && !full;
  wire do_rd = ce_in && rd_ready_in && !empty;
  // Ready comes from its own flop, worked out from the next pointers
  logic ready_reg;
  wire [AW:0] wptr_next = wptr_reg + {{AW{1'h0}}, do_wr};
  wire [AW:0] rptr_next = rptr_reg + {{AW{1'h0}}, do_rd};
  wire full_next = (wptr_next[AW-1:0] == rptr_next[AW-1:0]) && (wptr_next[AW] != rptr_next[AW]);
  assign wr_ready_out = ready_reg;
  assign rd_valid_out = !empty;
  assign rd_data_out = mem_reg[rptr_reg[AW-1:0]];
  always_ff @(posedge clk_in) begin
    if (do_wr) begin
      mem_reg[wptr_reg[AW-1:0]] <= wr_data_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      ready_reg <= 1'h1;
    end else begin
      ready_reg <= !full_next;
      if (do_wr) begin
        wptr_reg <= wptr_reg + 1'h1;
      end
      if (do_rd) begin
        rptr_reg <= rptr_reg + 1'h1;
      end
    end
  end
endmodule : ddr_fifo

/* ddr_io_cell.sv */
// DDR I/O cell: capture, launch, tristate and bidirectional modes
// Operation
// - The cell works in one of four modes: input, output, tristate output or bidirectional.
// - Input capture samples the pad on both edges through three registers for the rise half and four for the fall half and hands the pair over on each rising edge.
// - Any pad position can host the capture logic, since the cell has no position limit.
// - The output, tristate and bidirectional modes launch a new value every half clock while the FIFO holds pairs, and repeat the last pair when it is empty.
// - Small variants only allow DDR at the three largest densities.
// - Small variants refuse differential signalling for DDR pads.
// - Pad data changes on both clock edges and the far party samples or drives accordingly.
// - The tristate driver enable is active low.
// - The bidirectional enable is active low while capture keeps sampling the pad.
`timescale 1ns/10ps
module ddr_io_cell
  import ddr_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0,
  parameter int unsigned DENSITY_K = DDR_DENS_DEFAULT,
  parameter bit DIFFERENTIAL = 1'b0,
  parameter int unsigned FIFO_DEPTH = DDR_FIFO_DEPTH
) (
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic CE_IN,
  input wire logic [DDR_MODE_W-1:0] MODE_IN,
  input wire logic TX_VALID_IN,
  output logic TX_READY_OUT,
  input wire logic RISE_HALF_DATA_IN,
  input wire logic FALL_HALF_DATA_IN,
  input wire logic DRV_EN_N_IN,
  input wire logic PAD_IN,
  output logic PAD_OUT,
  output logic PAD_OE_N_OUT,
  output logic RX_VALID_OUT,
  output logic RISE_SAMPLE_OUT,
  output logic FALL_SAMPLE_OUT,
  output logic TX_UNDERRUN_OUT
);
  localparam bit DENS_OK = (DENSITY_K == DDR_DENS_SMALL_A) || (DENSITY_K == DDR_DENS_SMALL_B) ||
    (DENSITY_K == DDR_DENS_SMALL_C);
  generate
    if (SMALL_VARIANT && !DENS_OK) begin : g_dens
      $error("DDR is not available at this density on small variants");
    end
    if (SMALL_VARIANT && DIFFERENTIAL) begin : g_diff
      $error("Differential DDR pads are not available on small variants");
    end
  endgenerate
  ddr_mode_e mode;
  assign mode = ddr_mode_e'(MODE_IN);
  wire mode_capture = (mode == DDR_MODE_INPUT) || (mode == DDR_MODE_BIDIR);
  wire mode_launch = (mode != DDR_MODE_INPUT);
  wire mode_enabled = (mode == DDR_MODE_TRISTATE) || (mode == DDR_MODE_BIDIR);
  // Capture path: two flops per edge before use, then the fall half moves to the rising edge
  logic rise_s1_reg;
  logic rise_s2_reg;
  logic fall_s1_reg;
  logic fall_s2_reg;
  logic fall_s3_reg;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      rise_s1_reg <= DDR_BIT_CLEAR;
      rise_s2_reg <= DDR_BIT_CLEAR;
      fall_s3_reg <= DDR_BIT_CLEAR;
    end else if (CE_IN) begin
      rise_s1_reg <= PAD_IN;
      rise_s2_reg <= rise_s1_reg;
      fall_s3_reg <= fall_s2_reg;
    end
  end
  always_ff @(negedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      fall_s1_reg <= DDR_BIT_CLEAR;
      fall_s2_reg <= DDR_BIT_CLEAR;
    end else if (CE_IN) begin
      fall_s1_reg <= PAD_IN;
      fall_s2_reg <= fall_s1_reg;
    end
  end
  logic rise_sample_reg;
  logic fall_sample_reg;
  logic rx_valid_reg;
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      rise_sample_reg <= DDR_BIT_CLEAR;
      fall_sample_reg <= DDR_BIT_CLEAR;
      rx_valid_reg <= DDR_BIT_CLEAR;
    end else if (CE_IN) begin
      rx_valid_reg <= mode_capture;
      if (mode_capture) begin
        rise_sample_reg <= rise_s2_reg;
        fall_sample_reg <= fall_s3_reg;
      end
    end
  end
  // Transmit path: core pairs buffered, one pair launched per clock
  logic [DDR_PAIR_W-1:0] tx_pair_in;
  logic [DDR_PAIR_W-1:0] tx_pair_out;
  logic tx_avail;
  assign tx_pair_in = {RISE_HALF_DATA_IN, FALL_HALF_DATA_IN};
  ddr_fifo #(
    .WIDTH(DDR_PAIR_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .wr_valid_in(TX_VALID_IN),
    .wr_ready_out(TX_READY_OUT),
    .wr_data_in(tx_pair_in),
    .rd_valid_out(tx_avail),
    .rd_ready_in(mode_launch),
    .rd_data_out(tx_pair_out)
  );
  wire tx_load = mode_launch && tx_avail;
  ddr_launch u_launch (
    .clk_in(CLK_SYS_IN),
    .rst_n_in(RESETN_IN),
    .ce_in(CE_IN),
    .load_in(tx_load),
    .rise_half_data_in(tx_pair_out[DDR_PAIR_RISE]),
    .fall_half_data_in(tx_pair_out[DDR_PAIR_FALL]),
    .pad_data_out(PAD_OUT)
  );
  // Driver enable, low drives the pad
  logic oe_n_reg;
  logic underrun_reg;
  wire oe_n_next = !mode_launch ? DDR_OE_N_FLOAT :
    (mode_enabled ? DRV_EN_N_IN : DDR_OE_N_DRIVE);
  always_ff @(posedge CLK_SYS_IN) begin
    if (!RESETN_IN) begin
      oe_n_reg <= DDR_OE_N_FLOAT;
      underrun_reg <= DDR_BIT_CLEAR;
    end else if (CE_IN) begin
      oe_n_reg <= oe_n_next;
      underrun_reg <= mode_launch && !tx_avail;
    end
  end
  assign PAD_OE_N_OUT = oe_n_reg;
  assign RX_VALID_OUT = rx_valid_reg;
  assign RISE_SAMPLE_OUT = rise_sample_reg;
  assign FALL_SAMPLE_OUT = fall_sample_reg;
  assign TX_UNDERRUN_OUT = underrun_reg;
endmodule : ddr_io_cell

/* ddr_io_cell_assertions.sv */
// Port checks for the DDR I/O cell
`timescale 1ns/10ps
module ddr_io_cell_assertions
  import ddr_pkg::*;
(
  input wire logic CLK_SYS_IN,
  input wire logic RESETN_IN,
  input wire logic CE_IN,
  input wire logic [DDR_MODE_W-1:0] MODE_IN,
  input wire logic DRV_EN_N_IN,
  input wire logic PAD_IN,
  input wire logic PAD_OE_N_OUT,
  input wire logic RX_VALID_OUT,
  input wire logic RISE_SAMPLE_OUT,
  input wire logic FALL_SAMPLE_OUT,
  input wire logic TX_UNDERRUN_OUT
);
  logic [3:0] fall_hist_reg;
  wire cap_mode = MODE_IN == DDR_MODE_INPUT || MODE_IN == DDR_MODE_BIDIR;
  wire cap_run = CE_IN && cap_mode;
  always_ff @(negedge CLK_SYS_IN) fall_hist_reg <= {fall_hist_reg[2:0], PAD_IN};
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);
  oe_output_a: assert property (CE_IN && MODE_IN == DDR_MODE_OUTPUT |=> !PAD_OE_N_OUT)
    else $error("output mode not driving");
  oe_input_a: assert property (CE_IN && MODE_IN == DDR_MODE_INPUT |=> PAD_OE_N_OUT)
    else $error("input mode driving");
  oe_enable_a: assert property (CE_IN && MODE_IN[1] |=> PAD_OE_N_OUT == $past(DRV_EN_N_IN))
    else $error("enable not followed");
  rx_valid_a: assert property (CE_IN |=> RX_VALID_OUT == $past(cap_mode))
    else $error("rx valid wrong");
  rise_lat_a: assert property (cap_run [*3] |=> RISE_SAMPLE_OUT == $past(PAD_IN, 3))
    else $error("rise sample wrong");
  fall_lat_a: assert property (cap_run [*5] |=> FALL_SAMPLE_OUT == fall_hist_reg[3])
    else $error("fall sample wrong");
  ce_hold_a: assert property (!CE_IN |=> $stable(RISE_SAMPLE_OUT) && $stable(PAD_OE_N_OUT))
    else $error("state moved while frozen");
  no_underrun_a: assert property (CE_IN && MODE_IN == DDR_MODE_INPUT |=> !TX_UNDERRUN_OUT)
    else $error("underrun in input mode");
endmodule : ddr_io_cell_assertions

bind ddr_io_cell ddr_io_cell_assertions chk_u (.*);

/* ddr_launch.sv */
// Output launch registers, rise half after the rising edge, fall half after the falling edge
`timescale 1ns/10ps
module ddr_launch
  import ddr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic rise_half_data_in,
  input wire logic fall_half_data_in,
  output logic pad_data_out
);
  logic rise_reg;
  logic fall_hold_reg;
  logic fall_reg;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rise_reg <= DDR_BIT_CLEAR;
      fall_hold_reg <= DDR_BIT_CLEAR;
    end else if (ce_in && load_in) begin
      rise_reg <= rise_half_data_in;
      fall_hold_reg <= fall_half_data_in;
    end
  end
  always_ff @(negedge clk_in) begin
    if (!rst_n_in) begin
      fall_reg <= DDR_BIT_CLEAR;
    end else if (ce_in) begin
      fall_reg <= fall_hold_reg;
    end
  end
  // High phase shows the rise half, low phase the fall half
  assign pad_data_out = clk_in ? rise_reg : fall_reg;
endmodule : ddr_launch

/* ddr_pad_partner.sv */
// Far-side pad device model
`timescale 1ns/10ps
module ddr_pad_partner #(parameter logic [31:0] SEED = 32'h5a5a0f0f) (
  input wire logic clk_in,
  input wire logic drive_in,
  input wire logic slow_in,
  input wire logic data_in,
  input wire logic oe_n_in,
  output wire logic level_out
);
  logic [31:0] st = SEED;
  always @(clk_in) begin
    #2;
    if (clk_in || !slow_in) st = st ^ (st << 7) ^ (st >> 9);
  end
  // Pad wire delay keeps the driven level off the sampling edges
  assign #1 level_out = !oe_n_in ? data_in : (drive_in ? st[0] : st[4]);
endmodule : ddr_pad_partner

/* ddr_pkg.sv */
// Shared constants and types for the DDR I/O cell
package ddr_pkg;
  localparam int unsigned DDR_MODE_W = 2;
  typedef enum logic [DDR_MODE_W-1:0] {
    DDR_MODE_INPUT,
    DDR_MODE_OUTPUT,
    DDR_MODE_TRISTATE,
    DDR_MODE_BIDIR
  } ddr_mode_e;
  localparam int unsigned DDR_PAIR_W = 2;
  localparam int unsigned DDR_PAIR_RISE = 1;
  localparam int unsigned DDR_PAIR_FALL = 0;
  localparam int unsigned DDR_FIFO_DEPTH = 8;
  localparam int unsigned DDR_DENS_SMALL_A = 60;
  localparam int unsigned DDR_DENS_SMALL_B = 125;
  localparam int unsigned DDR_DENS_SMALL_C = 250;
  localparam int unsigned DDR_DENS_DEFAULT = 250;
  localparam logic DDR_OE_N_DRIVE = 1'h0;
  localparam logic DDR_OE_N_FLOAT = 1'h1;
  localparam logic DDR_BIT_CLEAR = 1'h0;
  localparam time DDR_CLK_PERIOD_NS = 20ns;
endpackage : ddr_pkg

/* tb_ddr_io_cell.sv */
// Random and corner tests for the DDR I/O cell
`timescale 1ns/10ps
module tb_ddr_io_cell;
  import ddr_pkg::*;
  logic clk, rst_n, ce, tx_v, rd, fd, den_n, far, slow, pad, po, oe_n, rdy, rxv, rs, fs, und;
  logic [1:0] mode, hr, hf;
  logic [2:0] rh, fh;
  logic [31:0] seed = 32'h014afe8b;
  int mismatches = 0;
  int checks_done = 0;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string n, input logic e, input logic g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  task automatic do_reset();
    @(posedge clk);
    #1 rst_n = 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("oe_n", 1'h1, oe_n);
    chk("ready", 1'h1, rdy);
    chk("cleared", 1'h0, rs | fs | rxv | po | und);
    rst_n = 1'h1;
    $display("reset test done");
  endtask : do_reset
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) rh <= {rh[1:0], pad};
  always @(negedge clk) fh <= {fh[1:0], pad};
  initial begin
    #20000;
    mismatches++;
    summarize();
  end
  ddr_io_cell dut_u (.CLK_SYS_IN(clk), .RESETN_IN(rst_n), .CE_IN(ce), .MODE_IN(mode),
    .TX_VALID_IN(tx_v), .TX_READY_OUT(rdy), .RISE_HALF_DATA_IN(rd), .FALL_HALF_DATA_IN(fd),
    .DRV_EN_N_IN(den_n), .PAD_IN(pad), .PAD_OUT(po), .PAD_OE_N_OUT(oe_n), .RX_VALID_OUT(rxv),
    .RISE_SAMPLE_OUT(rs), .FALL_SAMPLE_OUT(fs), .TX_UNDERRUN_OUT(und));
  ddr_pad_partner far_u (.clk_in(clk), .drive_in(far), .slow_in(slow), .data_in(po),
    .oe_n_in(oe_n), .level_out(pad));
  initial begin
    {rst_n, mode, tx_v, rd, fd, den_n, far, slow, hr, hf} = '0;
    ce = 1'h1;
    do_reset();
    far = 1'h1;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      #1;
      seed = xs(seed);
      {tx_v, rd, fd} = {1'h1, seed[1:0]};
      ce = i != 12;
      slow = i > 18;
      if (i == 7 || i == 8) chk("ready", i == 7, rdy);
      if (i > 4 && (i < 12 || i > 17)) begin
        chk("rise_sample", rh[2], rs);
        chk("fall_sample", fh[2], fs);
        chk("rx_valid", 1'h1, rxv);
      end
    end
    chk("ready", 1'h0, rdy);
    chk("oe_n", 1'h1, oe_n);
    $display("capture test done");
    {tx_v, far} = '0;
    for (int m = 1; m < 4; m++) begin
      @(posedge clk);
      #1;
      mode = 2'(m);
      den_n = 1'h0;
      repeat (12) @(posedge clk);
      for (int i = 0; i < 13; i++) begin
        @(posedge clk);
        #1;
        chk("oe_n", mode != DDR_MODE_OUTPUT && (!mode[1] || den_n), oe_n);
        hr = {hr[0], rd};
        hf = {hf[0], fd};
        seed = xs(seed);
        if (i < 9) {rd, fd} = seed[3:2];
        {tx_v, den_n} = {i < 9, i > 10 && m > 1};
        #4;
        if (i > 1) chk("pad_rise", hr[1], po);
        if (i > 1 && i < 9) chk("underrun", 1'h0, und);
        if (i == 11) chk("underrun", 1'h1, und);
        #10;
        if (i > 1) chk("pad_fall", hf[1], po);
      end
      $display("launch test done");
    end
    do_reset();
    @(posedge clk);
    #1;
    chk("rx_valid", 1'h1, rxv);
    chk("oe_n", den_n, oe_n);
    summarize();
  end
endmodule : tb_ddr_io_cell
